// ==== rtl/ucmd_defs.svh ====
// Command codes, limits and reset values of the command decoder
`ifndef UCMD_DEFS_SVH
`define UCMD_DEFS_SVH

`define UCMD_GRP_FIFO_WR   4'h0
`define UCMD_GRP_FIFO_RD   4'h1
`define UCMD_GRP_STALL     4'h4
`define UCMD_GRP_STATUS    4'h5
`define UCMD_GRP_VALIDATE  4'h6
`define UCMD_GRP_CLEAR     4'h7
`define UCMD_GRP_UNSTALL   4'h8
`define UCMD_GRP_ERRCODE   4'ha
`define UCMD_GRP_IMAGE     4'hd

`define UCMD_EP_CTRL_OUT   4'h0
`define UCMD_EP_CTRL_IN    4'h1

`define UCMD_CMD_UNLOCK    8'hb0
`define UCMD_CMD_DMAFS_WR  8'hb2
`define UCMD_CMD_DMAFS_RD  8'hb3
`define UCMD_CMD_DMACFG_WR 8'hf0
`define UCMD_CMD_DMACFG_RD 8'hf1
`define UCMD_CMD_DMACNT_WR 8'hf2
`define UCMD_CMD_DMACNT_RD 8'hf3
`define UCMD_CMD_ACK_SETUP 8'hf4

`define UCMD_UNLOCK_KEY    16'haa37
`define UCMD_BULK_MAX      10'h040
`define UCMD_ISO_MAX       10'h3ff
`define UCMD_REG16_RESET   16'h0000

`endif

// ==== rtl/ucmd_pkg.sv ====
// Types shared by the command decoder files
package ucmd_pkg;

    typedef enum logic [3:0] {
        UCMD_IDLE,
        UCMD_FIFO_WR,
        UCMD_FIFO_RD,
        UCMD_STAT_RD,
        UCMD_IMG_RD,
        UCMD_ERR_RD,
        UCMD_REG_WR,
        UCMD_REG_RD,
        UCMD_UNLOCK
    } ucmd_state_t;

    typedef enum logic [1:0] {
        UCMD_REG_DMAFS,
        UCMD_REG_DMACFG,
        UCMD_REG_DMACNT
    } ucmd_reg_t;

endpackage : ucmd_pkg

// ==== rtl/ucmd_reg16.sv ====
// Two-byte register loaded one byte at a time
`timescale 1ns/1ps
`include "ucmd_defs.svh"

module ucmd_reg16
(
    // Clock and reset
    input  logic        i_clk,
    input  logic        i_reset,
    // Byte loads
    input  logic        i_wr_lo,
    input  logic        i_wr_hi,
    input  logic [7:0]  i_data,
    // Register value
    output logic [15:0] o_q
);

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_q <= `UCMD_REG16_RESET;
        end
        else if (i_wr_lo)
        begin
            o_q[7:0] <= i_data;
        end
        else if (i_wr_hi)
        begin
            o_q[15:8] <= i_data;
        end
    end

endmodule : ucmd_reg16

// ==== rtl/ucmd_decoder.sv ====
// Command decoder of the parallel host port
`timescale 1ns/1ps
`include "ucmd_defs.svh"

// Contract
// - Select high takes command; no-data commands run
// - Multibyte registers move low byte first
// - Code 01 writes control IN FIFO, 64 max
// - Codes 02-0F write IN FIFOs, 1023/64 max
// - Code 10 reads control OUT FIFO, 64 max
// - Codes 12-1F read OUT FIFOs, 1023/64 max
// - Codes 40-4F stall endpoints, no data
// - Codes 80-8F unstall endpoints, no data
// - Codes 50-5F return endpoint status byte
// - Codes 61-6F validate IN buffers
// - Codes 70,72-7F clear OUT buffers; 71 illegal
// - Codes D0-DF return status image byte
// - Status image read clears nothing
// - Code F4 acknowledges setup, no data
// - B2/B3 write/read DMA function-scratch, 2 bytes
// - F0-F3 access DMA config and counter
// - Codes A0-AF return error code byte
// - Unlock takes two bytes, frees register writes
// - DMA register writes blocked after wake-up until AA37
module ucmd_decoder
    import ucmd_pkg::*;
(
    // Clock and reset
    input  logic        i_clk,
    input  logic        i_reset,
    // Host port, one strobe per transfer
    input  logic        i_wr,
    input  logic        i_rd,
    input  logic        i_command_select_line,
    input  logic [7:0]  i_data,
    output logic [7:0]  o_rdata,
    output logic        o_rvalid,
    // Endpoint side, values for the endpoint on o_ep_idx
    input  logic        i_ep_iso,
    input  logic [7:0]  i_fifo_rdata,
    input  logic [7:0]  i_ep_status,
    input  logic [7:0]  i_ep_err_code,
    input  logic        i_wakeup,
    // Endpoint actions
    output logic [3:0]  o_ep_idx,
    output logic        o_fifo_wr,
    output logic [7:0]  o_fifo_wdata,
    output logic        o_fifo_rd,
    output logic        o_status_rd,
    output logic        o_stall_set,
    output logic        o_stall_clr,
    output logic        o_validate,
    output logic        o_clear,
    output logic        o_ack_setup,
    // DMA registers and lock
    output logic [15:0] o_dma_func,
    output logic [15:0] o_dma_cfg,
    output logic [15:0] o_dma_cnt,
    output logic        o_locked
);

    ucmd_state_t state_r;
    ucmd_reg_t   reg_sel_r;
    logic [9:0]  byte_cnt_r;
    logic [7:0]  unlock_lo_r;
    logic [15:0] dma_q [3];
    logic        cmd_wr, dat_wr, dat_rd;
    logic [3:0]  grp, sub;
    logic [9:0]  limit;

    assign cmd_wr = i_wr && i_command_select_line;
    assign dat_wr = i_wr && !i_command_select_line;
    assign dat_rd = i_rd && !i_command_select_line;
    assign grp    = i_data[7:4];
    assign sub    = i_data[3:0];
    assign limit  = i_ep_iso ? `UCMD_ISO_MAX : `UCMD_BULK_MAX;

    // Command phase decode
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_r   <= UCMD_IDLE;
            reg_sel_r <= UCMD_REG_DMAFS;
            o_ep_idx  <= 4'h0;
        end
        else if (cmd_wr)
        begin
            o_ep_idx <= sub;
            if (grp == `UCMD_GRP_FIFO_WR && sub != `UCMD_EP_CTRL_OUT)
                state_r <= UCMD_FIFO_WR;
            else if (grp == `UCMD_GRP_FIFO_RD && sub != `UCMD_EP_CTRL_IN)
                state_r <= UCMD_FIFO_RD;
            else if (grp == `UCMD_GRP_STATUS)
                state_r <= UCMD_STAT_RD;
            else if (grp == `UCMD_GRP_IMAGE)
                state_r <= UCMD_IMG_RD;
            else if (grp == `UCMD_GRP_ERRCODE)
                state_r <= UCMD_ERR_RD;
            else if (i_data == `UCMD_CMD_UNLOCK)
                state_r <= UCMD_UNLOCK;
            else if (i_data == `UCMD_CMD_DMAFS_WR || i_data == `UCMD_CMD_DMAFS_RD)
            begin
                state_r   <= i_data[0] ? UCMD_REG_RD : UCMD_REG_WR;
                reg_sel_r <= UCMD_REG_DMAFS;
            end
            else if (i_data == `UCMD_CMD_DMACFG_WR || i_data == `UCMD_CMD_DMACFG_RD)
            begin
                state_r   <= i_data[0] ? UCMD_REG_RD : UCMD_REG_WR;
                reg_sel_r <= UCMD_REG_DMACFG;
            end
            else if (i_data == `UCMD_CMD_DMACNT_WR || i_data == `UCMD_CMD_DMACNT_RD)
            begin
                state_r   <= i_data[0] ? UCMD_REG_RD : UCMD_REG_WR;
                reg_sel_r <= UCMD_REG_DMACNT;
            end
            else
                state_r <= UCMD_IDLE;
        end
    end

    // Commands without a data phase run at once
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_stall_set <= 1'b0;
            o_stall_clr <= 1'b0;
            o_validate  <= 1'b0;
            o_clear     <= 1'b0;
            o_ack_setup <= 1'b0;
        end
        else
        begin
            o_stall_set <= cmd_wr && grp == `UCMD_GRP_STALL;
            o_stall_clr <= cmd_wr && grp == `UCMD_GRP_UNSTALL;
            o_validate  <= cmd_wr && grp == `UCMD_GRP_VALIDATE
                           && sub != `UCMD_EP_CTRL_OUT;
            o_clear     <= cmd_wr && grp == `UCMD_GRP_CLEAR
                           && sub != `UCMD_EP_CTRL_IN;
            o_ack_setup <= cmd_wr && i_data == `UCMD_CMD_ACK_SETUP;
        end
    end

    // Data phase byte position, restarted by each command
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            byte_cnt_r <= 10'h000;
        else if (cmd_wr)
            byte_cnt_r <= 10'h000;
        else if ((dat_wr || dat_rd) && byte_cnt_r != `UCMD_ISO_MAX)
            byte_cnt_r <= byte_cnt_r + 10'h001;
    end

    // FIFO transfers, bytes past the buffer limit dropped
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_fifo_wr    <= 1'b0;
            o_fifo_wdata <= 8'h00;
            o_fifo_rd    <= 1'b0;
        end
        else
        begin
            o_fifo_wr <= dat_wr && state_r == UCMD_FIFO_WR
                         && byte_cnt_r < limit;
            o_fifo_rd <= dat_rd && state_r == UCMD_FIFO_RD
                         && byte_cnt_r < limit;
            if (dat_wr)
                o_fifo_wdata <= i_data;
        end
    end

    // Read answers, one cycle after the strobe
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_rdata     <= 8'h00;
            o_rvalid    <= 1'b0;
            o_status_rd <= 1'b0;
        end
        else
        begin
            o_rvalid    <= dat_rd;
            o_status_rd <= dat_rd && state_r == UCMD_STAT_RD
                           && byte_cnt_r == 10'h000;
            if (dat_rd)
            begin
                o_rdata <= 8'h00;
                case (state_r)
                    UCMD_FIFO_RD:
                        if (byte_cnt_r < limit)
                            o_rdata <= i_fifo_rdata;
                    UCMD_STAT_RD, UCMD_IMG_RD:
                        if (byte_cnt_r == 10'h000)
                            o_rdata <= i_ep_status;
                    UCMD_ERR_RD:
                        if (byte_cnt_r == 10'h000)
                            o_rdata <= i_ep_err_code;
                    UCMD_REG_RD:
                        if (byte_cnt_r == 10'h000)
                            o_rdata <= dma_q[reg_sel_r][7:0];
                        else if (byte_cnt_r == 10'h001)
                            o_rdata <= dma_q[reg_sel_r][15:8];
                    default: o_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Write lock after wake-up, freed by the unlock key
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_locked    <= 1'b0;
            unlock_lo_r <= 8'h00;
        end
        else
        begin
            if (dat_wr && state_r == UCMD_UNLOCK && byte_cnt_r == 10'h000)
                unlock_lo_r <= i_data;
            if (i_wakeup)
                o_locked <= 1'b1;
            else if (dat_wr && state_r == UCMD_UNLOCK && byte_cnt_r == 10'h001
                     && {i_data, unlock_lo_r} == `UCMD_UNLOCK_KEY)
                o_locked <= 1'b0;
        end
    end

    // DMA registers, low byte first
    for (genvar g = 0; g < 3; g++)
    begin : g_dma
        logic sel;
        assign sel = dat_wr && state_r == UCMD_REG_WR && !o_locked
                     && reg_sel_r == ucmd_reg_t'(g);
        ucmd_reg16 u_reg
        (
            .i_clk   (i_clk),
            .i_reset (i_reset),
            .i_wr_lo (sel && byte_cnt_r == 10'h000),
            .i_wr_hi (sel && byte_cnt_r == 10'h001),
            .i_data  (i_data),
            .o_q     (dma_q[g])
        );
    end

    assign o_dma_func = dma_q[0];
    assign o_dma_cfg  = dma_q[1];
    assign o_dma_cnt  = dma_q[2];

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    sequence gap_s;
        !i_wr && !i_rd && !i_wakeup;
    endsequence
    sequence unlock_key_s;
        dat_wr && i_data == 8'h37 && !i_wakeup ##1 gap_s
        ##1 dat_wr && i_data == 8'haa && !i_wakeup;
    endsequence
    stall_set_now_a: assert property (cmd_wr && grp == 4'h4 |=>
        o_stall_set && o_ep_idx == $past(i_data[3:0])) else $error("stall command late");
    unstall_now_a: assert property (cmd_wr && grp == 4'h8 |=>
        o_stall_clr && !o_stall_set) else $error("unstall command late");
    validate_in_a: assert property (cmd_wr && grp == 4'h6 |=>
        o_validate == ($past(i_data[3:0]) != 4'h0)) else $error("validate decoded wrongly");
    clear_out_a: assert property (cmd_wr && grp == 4'h7 |=>
        o_clear == ($past(i_data[3:0]) != 4'h1)) else $error("clear decoded wrongly");
    ack_setup_a: assert property (cmd_wr && i_data == 8'hf4 |=> o_ack_setup)
        else $error("setup acknowledge missing");
    illegal_quiet_a: assert property (cmd_wr && (i_data == 8'h00 || i_data == 8'h11
        || i_data[7:5] == 3'h1) ##1 (!cmd_wr)[*3] |=> !o_fifo_wr && !o_fifo_rd)
        else $error("illegal code moved FIFO data");
    bulk_limit_a: assert property (state_r == UCMD_FIFO_WR && !i_ep_iso && dat_wr
        && byte_cnt_r == 10'h040 |=> !o_fifo_wr) else $error("bulk FIFO write past limit");
    status_read_a: assert property (state_r == UCMD_STAT_RD && dat_rd
        && byte_cnt_r == 10'h000 |=> o_rvalid && o_status_rd && o_rdata == $past(i_ep_status))
        else $error("status byte not returned");
    image_clean_a: assert property (state_r == UCMD_IMG_RD && dat_rd |=> !o_status_rd
        && (o_rdata == $past(i_ep_status) || $past(byte_cnt_r) != 10'h000))
        else $error("status image read disturbed status");
    unlock_key_a: assert property (cmd_wr && i_data == `UCMD_CMD_UNLOCK && !i_wakeup
        ##1 gap_s ##1 unlock_key_s |=> !o_locked) else $error("unlock key did not free writes");
    locked_hold_a: assert property (o_locked && state_r == UCMD_REG_WR && dat_wr
        |=> $stable(o_dma_cfg) && $stable(o_dma_func) && $stable(o_dma_cnt))
        else $error("DMA register changed while locked");
    low_first_a: assert property (cmd_wr && i_data == 8'hf0 && !o_locked && !i_wakeup
        ##1 gap_s ##1 dat_wr && !i_wakeup ##1 gap_s ##1 dat_wr
        |=> o_dma_cfg == {$past(i_data), $past(i_data, 3)})
        else $error("DMA configuration not loaded low byte first");
endmodule : ucmd_decoder

// ==== sim/ucmd_host_model.sv ====
// Host side model that drives the command port one byte at a time
`timescale 1ns/1ps

module ucmd_host_model
(
    // Clock
    input  logic       i_clk,
    // Read answer
    input  logic [7:0] i_rdata,
    input  logic       i_rvalid,
    // Strobes and data
    output logic       o_wr,
    output logic       o_rd,
    output logic       o_sel,
    output logic [7:0] o_data
);
    initial
    begin
        o_wr   = 1'b0;
        o_rd   = 1'b0;
        o_sel  = 1'b0;
        o_data = 8'h00;
    end

    // One strobed byte, answer taken in the cycle after the strobe
    task automatic xfer(input logic sel, input logic rd, input logic [7:0] d,
                        output logic [7:0] q, output logic v);
        @(posedge i_clk);
        o_sel  <= sel;
        o_rd   <= rd;
        o_wr   <= !rd;
        o_data <= d;
        @(posedge i_clk);
        o_wr   <= 1'b0;
        o_rd   <= 1'b0;
        o_data <= ~d;
        #1;
        q = i_rdata;
        v = i_rvalid;
    endtask : xfer
endmodule : ucmd_host_model

// ==== sim/usb_device_command_decoder_test.sv ====
// Self-checking bench of the command decoder
`timescale 1ns/1ps
`include "ucmd_defs.svh"

module usb_device_command_decoder_test;
    logic        i_clk, i_reset, i_wr, i_rd, i_command_select_line, i_ep_iso, i_wakeup;
    logic [7:0]  i_data, i_fifo_rdata, i_ep_status, i_ep_err_code, o_rdata, o_fifo_wdata;
    logic [3:0]  o_ep_idx;
    logic        o_rvalid, o_fifo_wr, o_fifo_rd, o_status_rd, o_stall_set, o_stall_clr;
    logic        o_validate, o_clear, o_ack_setup, o_locked;
    logic [15:0] o_dma_func, o_dma_cfg, o_dma_cnt;
    logic [7:0]  acts, q;
    logic        v;
    int          error_cnt = 0, comparisons = 0, pushes = 0, pops = 0;

    ucmd_decoder ucmd_decoder_inst (.i_clk, .i_reset, .i_wr, .i_rd, .i_command_select_line,
        .i_data, .o_rdata, .o_rvalid, .i_ep_iso, .i_fifo_rdata, .i_ep_status, .i_ep_err_code,
        .i_wakeup, .o_ep_idx, .o_fifo_wr, .o_fifo_wdata, .o_fifo_rd, .o_status_rd,
        .o_stall_set, .o_stall_clr, .o_validate, .o_clear, .o_ack_setup, .o_dma_func,
        .o_dma_cfg, .o_dma_cnt, .o_locked);

    ucmd_host_model ucmd_host_model_inst (.i_clk, .i_rdata(o_rdata), .i_rvalid(o_rvalid),
        .o_wr(i_wr), .o_rd(i_rd), .o_sel(i_command_select_line), .o_data(i_data));

    // Endpoint side: FIFO head follows the pop count
    assign i_fifo_rdata  = pops[7:0] ^ {o_ep_idx, 4'h0};
    assign i_ep_status   = {4'hc, o_ep_idx};
    assign i_ep_err_code = {4'h3, o_ep_idx};
    assign acts = {o_stall_set, o_stall_clr, o_validate, o_clear, o_ack_setup, o_fifo_wr,
                   o_fifo_rd, o_status_rd};

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    always @(posedge i_clk)
    begin
        pushes <= pushes + int'(o_fifo_wr);
        pops   <= pops + int'(o_fifo_rd);
    end

    task automatic end_of_test();
        $display("Errors %0d, comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic settle();
        @(posedge i_clk);
        #1;
    endtask : settle

    task automatic cmd(input logic [7:0] c);
        ucmd_host_model_inst.xfer(1'b1, 1'b0, c, q, v);
    endtask : cmd

    task automatic wr(input logic [7:0] d);
        ucmd_host_model_inst.xfer(1'b0, 1'b0, d, q, v);
    endtask : wr

    task automatic rd();
        ucmd_host_model_inst.xfer(1'b0, 1'b1, 8'h00, q, v);
    endtask : rd

    // Command pulse in the next cycle, gone one cycle later
    task automatic act(input logic [7:0] c, input logic [7:0] exp);
        cmd(c);
        chk({8'h00, acts}, {8'h00, exp});
        settle();
        chk({8'h00, acts}, 16'h0000);
    endtask : act

    task automatic t_actions();
        logic [7:0] bad [5] = '{8'h20, 8'h3f, 8'hb4, 8'hc0, 8'hf6};
        for (int i = 0; i < 16; i++)
        begin
            act(8'h40 + 8'(i), 8'h80);
            chk({12'h000, o_ep_idx}, 16'(i));
            act(8'h80 + 8'(i), 8'h40);
            if (i != 0)
                act(8'h60 + 8'(i), 8'h20);
            act(8'h70 + 8'(i), (i == 1) ? 8'h00 : 8'h10);
        end
        act(`UCMD_CMD_ACK_SETUP, 8'h08);
        foreach (bad[j])
        begin
            act(bad[j], 8'h00);
            rd();
            chk({7'h00, v, q}, 16'h0100);
        end
    endtask : t_actions

    task automatic t_fifo_wr(input logic [7:0] c, input logic iso, input int n, input int lim);
        int start;
        @(posedge i_clk);
        i_ep_iso <= iso;
        cmd(c);
        start = pushes;
        for (int k = 0; k < n; k++)
        begin
            wr(8'(k));
            chk({8'h00, o_fifo_wdata}, {8'h00, 8'(k)});
        end
        settle();
        chk(16'(pushes - start), 16'(lim));
    endtask : t_fifo_wr

    task automatic t_fifo_rd(input logic [7:0] c, input logic iso, input int n, input int lim);
        int start;
        logic [7:0] e;
        @(posedge i_clk);
        i_ep_iso <= iso;
        cmd(c);
        start = pops;
        for (int k = 0; k < n; k++)
        begin
            e = (k < lim) ? 8'(start + k) ^ {c[3:0], 4'h0} : 8'h00;
            rd();
            chk({7'h00, v, q}, {8'h01, e});
        end
        settle();
        chk(16'(pops - start), 16'(lim));
    endtask : t_fifo_rd

    task automatic t_reads();
        logic [7:0] grp [3] = '{8'h50, 8'hd0, 8'ha0};
        logic [7:0] e;
        foreach (grp[g])
            for (int i = 0; i < 16; i++)
            begin
                cmd(grp[g] + 8'(i));
                rd();
                e = (g == 2) ? {4'h3, 4'(i)} : {4'hc, 4'(i)};
                chk({6'h00, v, o_status_rd, q}, {6'h00, 1'b1, g == 0, e});
            end
    endtask : t_reads

    task automatic t_dma(input logic [7:0] c, input logic [15:0] val, input logic [15:0] exp,
                         input logic [1:0] sel);
        logic [15:0] port;
        cmd(c);
        wr(val[7:0]);
        wr(val[15:8]);
        settle();
        port = (sel == 0) ? o_dma_func : (sel == 1) ? o_dma_cfg : o_dma_cnt;
        chk(port, exp);
        cmd(c + 8'h01);
        rd();
        chk({8'h00, q}, {8'h00, exp[7:0]});
        rd();
        chk({8'h00, q}, {8'h00, exp[15:8]});
    endtask : t_dma

    task automatic unlock(input logic [15:0] key, input logic exp);
        cmd(`UCMD_CMD_UNLOCK);
        wr(key[7:0]);
        wr(key[15:8]);
        settle();
        chk({15'h0000, o_locked}, {15'h0000, exp});
    endtask : unlock

    task automatic t_lock();
        @(posedge i_clk);
        i_wakeup <= 1'b1;
        @(posedge i_clk);
        i_wakeup <= 1'b0;
        settle();
        chk({15'h0000, o_locked}, 16'h0001);
        t_dma(8'hf0, 16'h6655, 16'h2211, 2'h1);
        unlock(16'haa38, 1'b1);
        unlock(`UCMD_UNLOCK_KEY, 1'b0);
        t_dma(8'hf0, 16'h6655, 16'h6655, 2'h1);
    endtask : t_lock

    initial
    begin
        #500000;
        error_cnt++;
        end_of_test();
    end

    initial
    begin
        i_reset  = 1'b1;
        i_ep_iso = 1'b0;
        i_wakeup = 1'b0;
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        t_actions();
        t_fifo_wr(8'h01, 1'b0, 65, 64);
        t_fifo_wr(8'h02, 1'b0, 65, 64);
        t_fifo_wr(8'h0e, 1'b1, 1024, 1023);
        t_fifo_rd(8'h10, 1'b0, 65, 64);
        t_fifo_rd(8'h12, 1'b0, 65, 64);
        t_fifo_rd(8'h1f, 1'b1, 1024, 1023);
        t_reads();
        t_dma(8'hb2, 16'hbeef, 16'hbeef, 2'h0);
        t_dma(8'hf0, 16'h2211, 16'h2211, 2'h1);
        t_dma(8'hf2, 16'h0a5c, 16'h0a5c, 2'h2);
        t_lock();
        end_of_test();
    end
endmodule : usb_device_command_decoder_test
